// ### rtl/dls_pkg.sv
// Function
// - Set write activity flag after the write command end bit.
// - Set write activity flag when software resumes a halted write.
// - Clear write activity flag after CRC status of the last block.
// - With halt request pending, clear write flag after CRC status of that block.
// - Write flag falling through a halt request raises block gap event.
// - Write flag is one while write data is held, zero otherwise.
// - Bit 02 reports whether a card data line is in use.
// - Set data line flag after the read command end bit.
// - Set data line flag when software resumes a halted read.
// - Clear data line flag at end bit of the last read block.
// - Clear data line flag when a read halts at a block gap.
// - Read data line flag falling through halt raises block gap event.
// - Halt read at next block gap by read-wait or card clock stop.
// - Read-wait already driven for a full buffer may simply stay driven.
// - Read-wait signalling is supported for suspend and resume.
// - Write data line flag falling raises transfer complete event.
// - Clear write data line flag when card releases busy after last or halted block.
// - No busy within 8 card clocks means the card is not busy.
// - Data command inhibit is data line flag OR read activity flag.
package dls_pkg;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_EVENT = 4'h8;

  localparam int ST_INHIBIT_BIT = 1;
  localparam int ST_DLINE_BIT = 2;
  localparam int ST_WRACT_BIT = 8;
  localparam int ST_RDACT_BIT = 9;

  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_RESUME_BIT = 1;
  localparam int CTRL_RDWAIT_BIT = 2;
  localparam logic CTRL_RDWAIT_RST = 1'b1;

  localparam int EVT_GAP_BIT = 0;
  localparam int EVT_DONE_BIT = 1;

  localparam logic [3:0] BUSY_WAIT_CLKS = 4'h8;

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_XFER = 2'b01,
    W_BUSY = 2'b11,
    W_HALT = 2'b10
  } dls_wr_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_XFER = 2'b01,
    R_HALT = 2'b11
  } dls_rd_t;

  typedef struct packed {
    logic wrCmdEnd;
    logic rdCmdEnd;
    logic crcStatus;
    logic rdBlockEnd;
    logic lastBlock;
    logic bufFull;
    logic readXferActive;
  } dls_card_evt_t;

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdData;
    dls_wr_t wrState;
    dls_rd_t rdState;
    logic wrActive;
    logic dataLine;
    logic inhibit;
    logic haltReq;
    logic rdWaitEn;
    logic [1:0] evtSticky;
    logic gapPulse;
    logic donePulse;
    logic dat2Oe;
    logic cardClkEn;
    logic busySeen;
    logic gapHalt;
    logic [3:0] busyCnt;
    logic [2:0] clkSync;
    logic [1:0] dat0Sync;
  } dls_state_t;

endpackage

// ### rtl/dls_status.sv
`timescale 1ns/1ps
module dls_status
  import dls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire dls_card_evt_t cardEvt,
  input wire logic cardClkIn,
  input wire logic dat0In,
  output logic dat2Out,
  output logic dat2Oe,
  output logic cardClkEn,
  output logic wrActive,
  output logic dataLineActive,
  output logic dataCmdInhibit,
  output logic blockGapEvt,
  output logic xferCompleteEvt
);

  dls_state_t cur_ff;
  dls_state_t nxt_st;

  logic busRd;
  logic busWr;
  logic resumeReq;
  logic cardRise;
  logic cardBusy;

  always_comb begin
    nxt_st = cur_ff;
    busRd = avs_read && cur_ff.waitReq;
    busWr = avs_write && !cur_ff.waitReq;
    resumeReq = 1'b0;
    // Only the last two sync stages feed logic
    cardRise = cur_ff.clkSync[1] && !cur_ff.clkSync[2];
    cardBusy = !cur_ff.dat0Sync[1];
    nxt_st.clkSync = {cur_ff.clkSync[1:0], cardClkIn};
    nxt_st.dat0Sync = {cur_ff.dat0Sync[0], dat0In};
    nxt_st.gapPulse = 1'b0;
    nxt_st.donePulse = 1'b0;

    // One wait cycle per access; the word is latched while waitrequest is still high
    nxt_st.waitReq = !((avs_read || avs_write) && cur_ff.waitReq);
    if (busRd) begin
      nxt_st.rdData = 32'h0000_0000;
      if (avs_address == ADDR_STATUS) begin
        nxt_st.rdData[ST_INHIBIT_BIT] = cur_ff.inhibit;
        nxt_st.rdData[ST_DLINE_BIT] = cur_ff.dataLine;
        nxt_st.rdData[ST_WRACT_BIT] = cur_ff.wrActive;
        nxt_st.rdData[ST_RDACT_BIT] = cardEvt.readXferActive;
      end else if (avs_address == ADDR_CTRL) begin
        nxt_st.rdData[CTRL_HALT_BIT] = cur_ff.haltReq;
        nxt_st.rdData[CTRL_RDWAIT_BIT] = cur_ff.rdWaitEn;
      end else if (avs_address == ADDR_EVENT) begin
        nxt_st.rdData[1:0] = cur_ff.evtSticky;
      end
    end
    // Status word has no write path at all
    if (busWr) begin
      if (avs_address == ADDR_CTRL) begin
        nxt_st.haltReq = avs_writedata[CTRL_HALT_BIT];
        nxt_st.rdWaitEn = avs_writedata[CTRL_RDWAIT_BIT];
        resumeReq = avs_writedata[CTRL_RESUME_BIT];
      end else if (avs_address == ADDR_EVENT) begin
        nxt_st.evtSticky = cur_ff.evtSticky & ~avs_writedata[1:0];
      end
    end

    case (cur_ff.wrState)
      W_IDLE: begin
        if (cardEvt.wrCmdEnd) begin
          nxt_st.wrState = W_XFER;
          nxt_st.wrActive = 1'b1;
          nxt_st.dataLine = 1'b1;
        end
      end
      W_XFER: begin
        if (cardEvt.crcStatus && (cardEvt.lastBlock || cur_ff.haltReq)) begin
          nxt_st.wrState = W_BUSY;
          nxt_st.wrActive = 1'b0;
          nxt_st.busySeen = 1'b0;
          nxt_st.busyCnt = 4'h0;
          nxt_st.gapHalt = !cardEvt.lastBlock;
          if (!cardEvt.lastBlock) begin
            nxt_st.gapPulse = 1'b1;
          end
        end
      end
      W_BUSY: begin
        if (cardBusy) begin
          nxt_st.busySeen = 1'b1;
        end else if (cur_ff.busySeen || (cardRise && cur_ff.busyCnt == BUSY_WAIT_CLKS - 4'h1)) begin
          nxt_st.wrState = cur_ff.gapHalt ? W_HALT : W_IDLE;
          nxt_st.dataLine = 1'b0;
          nxt_st.donePulse = 1'b1;
        end else if (cardRise) begin
          nxt_st.busyCnt = cur_ff.busyCnt + 4'h1;
        end
      end
      W_HALT: begin
        if (resumeReq) begin
          nxt_st.wrState = W_XFER;
          nxt_st.wrActive = 1'b1;
          nxt_st.dataLine = 1'b1;
        end
      end
      default: nxt_st.wrState = W_IDLE;
    endcase

    case (cur_ff.rdState)
      R_IDLE: begin
        if (cardEvt.rdCmdEnd) begin
          nxt_st.rdState = R_XFER;
          nxt_st.dataLine = 1'b1;
        end
      end
      R_XFER: begin
        // Read-wait for a full buffer only where the card honours it
        nxt_st.dat2Oe = cardEvt.bufFull && cur_ff.rdWaitEn;
        if (cardEvt.rdBlockEnd && cardEvt.lastBlock) begin
          nxt_st.rdState = R_IDLE;
          nxt_st.dataLine = 1'b0;
          nxt_st.dat2Oe = 1'b0;
        end else if (cardEvt.rdBlockEnd && cur_ff.haltReq) begin
          nxt_st.rdState = R_HALT;
          nxt_st.dataLine = 1'b0;
          nxt_st.gapPulse = 1'b1;
          nxt_st.dat2Oe = cur_ff.rdWaitEn || cur_ff.dat2Oe;
          nxt_st.cardClkEn = cur_ff.rdWaitEn || cur_ff.dat2Oe;
        end
      end
      R_HALT: begin
        if (resumeReq) begin
          nxt_st.rdState = R_XFER;
          nxt_st.dataLine = 1'b1;
          nxt_st.dat2Oe = 1'b0;
          nxt_st.cardClkEn = 1'b1;
        end
      end
      default: nxt_st.rdState = R_IDLE;
    endcase

    // Set wins over a same-cycle software clear
    if (nxt_st.gapPulse) begin
      nxt_st.evtSticky[EVT_GAP_BIT] = 1'b1;
    end
    if (nxt_st.donePulse) begin
      nxt_st.evtSticky[EVT_DONE_BIT] = 1'b1;
    end
    nxt_st.inhibit = nxt_st.dataLine || cardEvt.readXferActive;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
      cur_ff.waitReq <= 1'b1;
      cur_ff.wrState <= W_IDLE;
      cur_ff.rdState <= R_IDLE;
      cur_ff.rdWaitEn <= CTRL_RDWAIT_RST;
      cur_ff.cardClkEn <= 1'b1;
      cur_ff.clkSync <= 3'h0;
      cur_ff.dat0Sync <= 2'h3;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign avs_readdata = cur_ff.rdData;
  assign avs_waitrequest = cur_ff.waitReq;
  // Read-wait pulls the data line low; only the enable moves
  assign dat2Out = 1'b0;
  assign dat2Oe = cur_ff.dat2Oe;
  assign cardClkEn = cur_ff.cardClkEn;
  assign wrActive = cur_ff.wrActive;
  assign dataLineActive = cur_ff.dataLine;
  assign dataCmdInhibit = cur_ff.inhibit;
  assign blockGapEvt = cur_ff.gapPulse;
  assign xferCompleteEvt = cur_ff.donePulse;

  a_write_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_IDLE && cardEvt.wrCmdEnd) |=> (wrActive && dataLineActive))
    else $error("write flag not set after command end");

  a_write_resume: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_HALT && busWr && avs_address == ADDR_CTRL && avs_writedata[CTRL_RESUME_BIT])
    |=> (wrActive && cur_ff.wrState == W_XFER))
    else $error("write flag not set on resume");

  a_write_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_XFER && cardEvt.crcStatus && cardEvt.lastBlock)
    |=> (!wrActive && dataLineActive && !blockGapEvt))
    else $error("write flag not cleared after last CRC status");

  a_write_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_XFER && cardEvt.crcStatus && !cardEvt.lastBlock && cur_ff.haltReq)
    |=> (!wrActive && blockGapEvt) ##1 !blockGapEvt)
    else $error("block gap event missing on halted write");

  a_busy_timeout: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_BUSY && !cur_ff.busySeen && !cardBusy && cardRise
      && cur_ff.busyCnt == BUSY_WAIT_CLKS - 4'h1)
    |=> (xferCompleteEvt && !dataLineActive))
    else $error("busy timeout did not end transfer");

  a_read_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_IDLE && cardEvt.rdCmdEnd) |=> dataLineActive)
    else $error("data line flag not set after read command");

  a_read_halt: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_XFER && cardEvt.rdBlockEnd && !cardEvt.lastBlock && cur_ff.haltReq)
    |=> (!dataLineActive && blockGapEvt && (dat2Oe || !cardClkEn)))
    else $error("read not halted at block gap");

  a_inhibit_or: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 (dataCmdInhibit == (dataLineActive || $past(cardEvt.readXferActive))))
    else $error("inhibit is not the OR of activity flags");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !avs_waitrequest |-> (avs_readdata[7:3] == 5'h00))
    else $error("reserved status bits not zero");

  a_halt_write_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_XFER && cardEvt.crcStatus && cur_ff.haltReq)
    |=> (!wrActive && cur_ff.wrState == W_BUSY))
    else $error("write flag not cleared at halted block");

  a_write_flag_state: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wrActive
    == (cur_ff.wrState == W_XFER)))
    else $error("write flag does not follow write data held");

  a_dline_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!avs_waitrequest && $past(avs_read) && $past(avs_address) == ADDR_STATUS)
    |-> (avs_readdata[ST_DLINE_BIT] == $past(dataLineActive)))
    else $error("status data line bit differs from flag");

  a_wract_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!avs_waitrequest && $past(avs_read) && $past(avs_address) == ADDR_STATUS)
    |-> (avs_readdata[ST_WRACT_BIT] == $past(wrActive)))
    else $error("status write bit differs from flag");

  a_read_resume: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_HALT && busWr && avs_address == ADDR_CTRL && avs_writedata[CTRL_RESUME_BIT])
    |=> (dataLineActive && !dat2Oe && cardClkEn))
    else $error("read not restarted on resume");

  a_read_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_XFER && cardEvt.rdBlockEnd && cardEvt.lastBlock)
    |=> (!dataLineActive && !blockGapEvt && cur_ff.rdState == R_IDLE))
    else $error("data line flag not cleared at last read block");

  a_read_gap_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_XFER && cardEvt.rdBlockEnd && !cardEvt.lastBlock && cur_ff.haltReq)
    |=> (!dataLineActive && cur_ff.rdState == R_HALT))
    else $error("data line flag not cleared at read halt");

  a_read_gap_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_XFER && cardEvt.rdBlockEnd && !cardEvt.lastBlock && cur_ff.haltReq)
    |=> blockGapEvt ##1 !blockGapEvt)
    else $error("block gap event missing on halted read");

  a_rdwait_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_XFER && cardEvt.rdBlockEnd && !cardEvt.lastBlock && cur_ff.haltReq
      && dat2Oe) |=> dat2Oe)
    else $error("read-wait dropped at block gap");

  a_rdwait_halt: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_XFER && cardEvt.rdBlockEnd && !cardEvt.lastBlock && cur_ff.haltReq
      && cur_ff.rdWaitEn) |=> (dat2Oe && cardClkEn))
    else $error("read-wait not used for halt");

  a_clock_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.rdState == R_XFER && cardEvt.rdBlockEnd && !cardEvt.lastBlock && cur_ff.haltReq
      && !cur_ff.rdWaitEn && !dat2Oe) |=> (!dat2Oe && !cardClkEn))
    else $error("card clock not stopped for halt");

  a_done_source: assert property (@(posedge clk_sys) disable iff (!arst_n)
    xferCompleteEvt
    |-> (!dataLineActive && $past(cur_ff.wrState) == W_BUSY))
    else $error("transfer complete without write data line fall");

  a_done_single: assert property (@(posedge clk_sys) disable iff (!arst_n)
    xferCompleteEvt
    |=> !xferCompleteEvt)
    else $error("transfer complete longer than one cycle");

  a_busy_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_BUSY && cur_ff.busySeen && !cardBusy)
    |=> (!dataLineActive && xferCompleteEvt))
    else $error("data line flag not cleared on busy release");

  a_busy_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_BUSY && cardBusy)
    |=> (cur_ff.wrState == W_BUSY && dataLineActive))
    else $error("write ended while card busy");

  a_halt_after_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (xferCompleteEvt && $past(cur_ff.gapHalt))
    |-> (cur_ff.wrState == W_HALT))
    else $error("halted write did not wait for resume");

  a_last_to_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (xferCompleteEvt && !$past(cur_ff.gapHalt))
    |-> (cur_ff.wrState == W_IDLE))
    else $error("last block write did not return to idle");

  a_status_ro: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (busWr && avs_address == ADDR_STATUS && cur_ff.wrState == W_XFER && !cardEvt.crcStatus)
    |=> wrActive)
    else $error("status write changed write flag");

  a_inhibit_dline: assert property (@(posedge clk_sys) disable iff (!arst_n)
    dataLineActive
    |-> dataCmdInhibit)
    else $error("inhibit low while data line active");

  a_busy_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_BUSY && !cur_ff.busySeen && !cardBusy && cardRise && cur_ff.busyCnt != BUSY_WAIT_CLKS - 4'h1)
    |=> (cur_ff.wrState == W_BUSY && dataLineActive))
    else $error("busy wait ended before timeout");

  a_gap_needs_halt: assert property (@(posedge clk_sys) disable iff (!arst_n)
    blockGapEvt
    |-> (!wrActive && $past(cur_ff.haltReq)))
    else $error("block gap event without halt request");

  a_halt_waits: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cur_ff.wrState == W_HALT && !resumeReq)
    |=> (cur_ff.wrState == W_HALT && !wrActive))
    else $error("halted write left halt without resume");

  a_gap_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
    blockGapEvt
    |-> cur_ff.evtSticky[EVT_GAP_BIT])
    else $error("block gap event not latched");

  a_done_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
    xferCompleteEvt
    |-> cur_ff.evtSticky[EVT_DONE_BIT])
    else $error("transfer complete event not latched");

endmodule

// ### testbench/dls_card_model.sv
`timescale 1ns/1ps
module dls_card_model (
  input wire logic clk_sys,
  input wire logic frame,
  input wire logic busyReq,
  input wire logic [7:0] busyLen,
  output logic cardClkIn,
  output logic dat0In
);
  logic [1:0] divCnt;
  logic [7:0] busyCnt;
  initial begin
    cardClkIn = 1'b0;
    divCnt = 2'h0;
    busyCnt = 8'h00;
  end
  // Card clock of 800 ns, held low outside frames
  always @(posedge clk_sys) begin
    if (frame) begin
      divCnt <= divCnt + 2'h1;
      if (divCnt == 2'h3) cardClkIn <= ~cardClkIn;
    end else begin
      divCnt <= 2'h0;
      cardClkIn <= 1'b0;
    end
    if (busyReq) busyCnt <= busyLen;
    else if (busyCnt != 8'h00 && divCnt == 2'h3) busyCnt <= busyCnt - 8'h01;
  end
  // Pull-up on the busy line; zero length means the card never signals busy
  assign dat0In = (busyCnt == 8'h00);
endmodule

// ### testbench/dls_status_tb.sv
`timescale 1ns/1ps
module dls_status_tb;
  import dls_pkg::*;
  logic clk_sys, arst_n, avs_read, avs_write, cardClkIn, dat0In, frame, busyReq;
  logic avs_waitrequest, dat2Out, dat2Oe, cardClkEn, wrActive, dataLineActive;
  logic dataCmdInhibit, blockGapEvt, xferCompleteEvt;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] busyLen;
  logic [6:0] lvl;
  dls_card_evt_t cardEvt;
  int fails, samples_checked, n;
  dls_status dls_status_i (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cardEvt(cardEvt),
    .cardClkIn(cardClkIn), .dat0In(dat0In), .dat2Out(dat2Out), .dat2Oe(dat2Oe),
    .cardClkEn(cardClkEn), .wrActive(wrActive), .dataLineActive(dataLineActive),
    .dataCmdInhibit(dataCmdInhibit), .blockGapEvt(blockGapEvt), .xferCompleteEvt(xferCompleteEvt));
  dls_card_model dls_card_model_i (.clk_sys(clk_sys), .frame(frame), .busyReq(busyReq),
    .busyLen(busyLen), .cardClkIn(cardClkIn), .dat0In(dat0In));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      fails++;
      finish_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One-cycle card event on top of the level fields
  task automatic ev(input logic [6:0] e);
    @(posedge clk_sys);
    cardEvt <= dls_card_evt_t'(e | lvl);
    @(posedge clk_sys);
    cardEvt <= dls_card_evt_t'(lvl);
  endtask
  task automatic waitFor(input int sel);
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk_sys);
      if ((sel == 0 && blockGapEvt === 1'b1) || (sel == 1 && xferCompleteEvt === 1'b1)) break;
      if (sel == 2 && dataLineActive === 1'b0) break;
    end
    if (k == 300) begin
      fails++;
      finish_test();
    end
  endtask
  function automatic logic [31:0] stExp(input logic w, input logic d, input logic r);
    return {22'h0, r, w, 5'h00, d, d | r, 1'b0};
  endfunction
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    cardEvt = '0;
    lvl = 7'h00;
    frame = 1'b0;
    busyReq = 1'b0;
    busyLen = 8'h00;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32'hD130));
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, stExp(1'b0, 1'b0, 1'b0));
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h4);
    // Pass 0: card signals busy; pass 1: card never drives busy
    for (n = 0; n < 2; n++) begin
      ev(7'h40);
      @(negedge clk_sys);
      chk({wrActive, dataLineActive}, 2'b11);
      bus(1'b1, ADDR_STATUS, $urandom());
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, stExp(1'b1, 1'b1, 1'b0));
      repeat ($urandom_range(3, 0)) ev(7'h10);
      chk(wrActive, 1'b1);
      frame <= 1'b1;
      busyLen <= (n == 0) ? 8'($urandom_range(30, 1)) : 8'h00;
      ev(7'h14);
      @(negedge clk_sys);
      chk(wrActive, 1'b0);
      @(posedge clk_sys);
      busyReq <= 1'b1;
      @(posedge clk_sys);
      busyReq <= 1'b0;
      waitFor(1);
      chk(dataLineActive, 1'b0);
      frame <= 1'b0;
    end
    bus(1'b0, ADDR_EVENT, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, ADDR_EVENT, 32'h3);
    bus(1'b0, ADDR_EVENT, 32'h0);
    chk(rd, 32'h0);
    // Halted write, then resume and finish
    bus(1'b1, ADDR_CTRL, 32'h5);
    frame <= 1'b1;
    ev(7'h40);
    ev(7'h10);
    waitFor(0);
    chk(wrActive, 1'b0);
    waitFor(2);
    chk(dataLineActive, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h6);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({wrActive, dataLineActive}, 2'b11);
    ev(7'h14);
    waitFor(2);
    frame <= 1'b0;
    // Plain read with the read activity level driven
    lvl <= 7'h01;
    ev(7'h20);
    @(negedge clk_sys);
    chk(dataLineActive, 1'b1);
    chk(dataCmdInhibit, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, stExp(1'b0, 1'b1, 1'b1));
    ev(7'h08);
    ev(7'h0C);
    @(negedge clk_sys);
    chk(dataLineActive, 1'b0);
    @(posedge clk_sys);
    lvl <= 7'h00;
    cardEvt <= '0;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, stExp(1'b0, 1'b0, 1'b0));
    // Halted read: pass 0 by read-wait, pass 1 by card clock stop
    for (n = 0; n < 2; n++) begin
      bus(1'b1, ADDR_CTRL, (n == 0) ? 32'h4 : 32'h0);
      ev(7'h20);
      repeat ($urandom_range(2, 0)) ev(7'h08);
      // Halt asked only after the free blocks, so the first gap seen is the halting one
      bus(1'b1, ADDR_CTRL, (n == 0) ? 32'h5 : 32'h1);
      ev(7'h08);
      waitFor(0);
      chk(dataLineActive, 1'b0);
      chk({dat2Out, dat2Oe, cardClkEn}, (n == 0) ? 3'b011 : 3'b000);
      bus(1'b1, ADDR_CTRL, (n == 0) ? 32'h6 : 32'h2);
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({dataLineActive, dat2Oe, cardClkEn}, 3'b101);
      ev(7'h0C);
    end
    finish_test();
  end
endmodule
